// file: pkg/qlfc_regs.svh
// register map, field positions, reset values and timing counts of the
// quad low-side fault control block; assumes a 100 MHz ref_clk_i
`ifndef QLFC_REGS_SVH
`define QLFC_REGS_SVH

// clock period in ns
`define QLFC_CLK_PERIOD_NS 10
// overcurrent deglitch time in ns, and its count (longest time, rounded down)
`define QLFC_OC_DEGLITCH_NS 3500
`define QLFC_OC_DEGLITCH_CYC (`QLFC_OC_DEGLITCH_NS / `QLFC_CLK_PERIOD_NS)
// overcurrent retry time in ns; its count is a top-level parameter
`define QLFC_OC_RETRY_NS 1200000
// width of the per-channel timer
`define QLFC_CNT_W 17

// register byte offsets
`define QLFC_CTRL_OFS 4'h0
`define QLFC_STATUS_OFS 4'h4
`define QLFC_INT_STAT_OFS 4'h8
`define QLFC_INT_MASK_OFS 4'hC

// control register: per-channel allow bits
`define QLFC_CTRL_ALLOW_LSB 0
`define QLFC_CTRL_RST 4'hF

// status register fields
`define QLFC_ST_OUT_LSB 0
`define QLFC_ST_OC_LSB 4
`define QLFC_ST_THERM_BIT 8
`define QLFC_ST_UNDERVOLTAGE_LOCKOUT_BIT 9
`define QLFC_ST_PIN_BIT 10
`define QLFC_ST_RSTPIN_BIT 11
`define QLFC_ST_IN_LSB 12

// interrupt status and mask fields
`define QLFC_INT_OC_LSB 0
`define QLFC_INT_THERM_BIT 4
`define QLFC_INT_UNDERVOLTAGE_LOCKOUT_BIT 5
`define QLFC_INT_W 6
`define QLFC_INT_MASK_RST 6'h00

`endif

// file: pkg/qlfc_pkg.sv
// types shared by the quad low-side fault control design
// assumes qlfc_regs.svh is on the include path
`include "qlfc_regs.svh"

package qlfc_pkg;

  // per-channel overcurrent state
  typedef enum logic [0:0] {
    QLFC_OC_RUN = 1'b0,
    QLFC_OC_OFF = 1'b1
  } qlfc_oc_state_t;

  // state of one channel's protection timer
  typedef struct packed {
    qlfc_oc_state_t st;
    logic [`QLFC_CNT_W-1:0] cnt;
  } qlfc_chan_state_t;

  // state of the top level
  typedef struct packed {
    logic [3:0] out;
    logic fault_oe_n;
    logic irq;
    logic [3:0] ctrl;
    logic [`QLFC_INT_W-1:0] int_stat;
    logic [`QLFC_INT_W-1:0] int_mask;
    logic therm_prev;
    logic undervoltage_lockout_prev;
    logic wr_pend;
    logic [3:0] wr_addr;
    logic [31:0] rdata;
  } qlfc_top_state_t;

endpackage

// file: src/qlfc_chan.sv
// overcurrent deglitch and retry timer of one low-side channel
// assumes a 100 MHz clock and a current limit flag synchronous to it
`timescale 1ns/1ns
`include "qlfc_regs.svh"

module qlfc_chan
  import qlfc_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = 120000
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic limit_i,
  input wire logic drive_i,
  output logic fault_o,
  output logic trip_o
);

  localparam logic [`QLFC_CNT_W-1:0] DEG_CNT = `QLFC_CNT_W'(`QLFC_OC_DEGLITCH_CYC);
  localparam logic [`QLFC_CNT_W-1:0] RETRY_LAST = `QLFC_CNT_W'(RETRY_CYCLES - 1);

  qlfc_chan_state_t cur_ff;
  qlfc_chan_state_t nxt_cur;
  logic trip;

  // deglitch while driving into the limit, then hold off for the retry time
  always_comb begin
    nxt_cur = cur_ff;
    trip = 1'b0;
    unique case (cur_ff.st)
      QLFC_OC_RUN: begin
        if (limit_i && drive_i) begin
          if (cur_ff.cnt == DEG_CNT) begin
            trip = 1'b1;
            nxt_cur.st = QLFC_OC_OFF;
            nxt_cur.cnt = '0;
          end else begin
            nxt_cur.cnt = cur_ff.cnt + 1'b1;
          end
        end else begin
          nxt_cur.cnt = '0; // limit or drive released before deglitch ran out
        end
      end
      QLFC_OC_OFF: begin
        if (cur_ff.cnt == RETRY_LAST) begin
          nxt_cur.st = QLFC_OC_RUN;
          nxt_cur.cnt = '0;
        end else begin
          nxt_cur.cnt = cur_ff.cnt + 1'b1;
        end
      end
    endcase
    if (clear_i) begin
      nxt_cur.st = QLFC_OC_RUN;
      nxt_cur.cnt = '0;
      trip = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cur_ff <= '{st: QLFC_OC_RUN, cnt: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign fault_o = (cur_ff.st == QLFC_OC_OFF);
  assign trip_o = trip;

endmodule // qlfc_chan

// file: src/qlfc_top.sv
// control and protection logic of a four-channel protected low-side switch,
// with an AHB-Lite register slave and one level interrupt
// assumes all pins are synchronous to the 100 MHz ref_clk_i and that the
// pulldowns on the enable and reset pins live in the pad ring
`timescale 1ns/1ns
`include "qlfc_regs.svh"

module qlfc_top
  import qlfc_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = `QLFC_OC_RETRY_NS / `QLFC_CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // parallel control pins
  input wire logic [3:0] channel_input_i,
  input wire logic outputs_enable_low_i,
  input wire logic logic_reset_i,
  // analog monitors
  input wire logic [3:0] current_limit_i,
  input wire logic thermal_shutdown_i,
  input wire logic undervoltage_lockout_i,
  // switch gates
  output logic [3:0] channel_output_o,
  // open-drain fault pin
  input wire logic fault_flag_low_i,
  output logic fault_flag_low_o,
  output logic fault_flag_low_oe_n_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // interrupt
  output logic irq_o
);

  qlfc_top_state_t cur_ff;
  qlfc_top_state_t nxt_cur;

  logic chan_clear;
  logic enabled;
  logic [3:0] oc_fault;
  logic [3:0] oc_trip;
  logic [3:0] drive_req;
  logic any_fault;
  logic addr_phase;
  logic [3:0] addr_ofs;
  logic [31:0] status_word;
  logic [`QLFC_INT_W-1:0] events;
  logic [`QLFC_INT_W-1:0] w1c;

  // the channel timers and gates are held in reset by the pin or by lockout of the supply
  assign chan_clear = logic_reset_i | undervoltage_lockout_i;

  // low enables the outputs; the pad pulldown makes a floating pin low
  assign enabled = ~outputs_enable_low_i;

  // one protection timer per channel
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      qlfc_chan #(
        .RETRY_CYCLES(RETRY_CYCLES)
      ) u_chan (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(chan_clear),
        .limit_i(current_limit_i[gi]),
        .drive_i(cur_ff.out[gi]),
        .fault_o(oc_fault[gi]),
        .trip_o(oc_trip[gi])
      );
    end
  endgenerate

  // gate each channel input by enable, software allow, faults and reset
  always_comb begin
    drive_req = channel_input_i & cur_ff.ctrl & ~oc_fault;
    if (!enabled || thermal_shutdown_i || chan_clear) begin
      drive_req = 4'h0;
    end
  end

  // fault pin pulls low only while an overcurrent or thermal fault stands
  assign any_fault = (|oc_fault) | thermal_shutdown_i;

  // events that set sticky interrupt bits
  always_comb begin
    events = '0;
    events[`QLFC_INT_OC_LSB +: 4] = oc_trip;
    events[`QLFC_INT_THERM_BIT] = thermal_shutdown_i & ~cur_ff.therm_prev;
    events[`QLFC_INT_UNDERVOLTAGE_LOCKOUT_BIT] = undervoltage_lockout_i & ~cur_ff.undervoltage_lockout_prev;
  end

  // live status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`QLFC_ST_OUT_LSB +: 4] = cur_ff.out;
    status_word[`QLFC_ST_OC_LSB +: 4] = oc_fault;
    status_word[`QLFC_ST_THERM_BIT] = thermal_shutdown_i;
    status_word[`QLFC_ST_UNDERVOLTAGE_LOCKOUT_BIT] = undervoltage_lockout_i;
    status_word[`QLFC_ST_PIN_BIT] = fault_flag_low_i;
    status_word[`QLFC_ST_RSTPIN_BIT] = logic_reset_i;
    status_word[`QLFC_ST_IN_LSB +: 4] = channel_input_i;
  end

  // bus address phase decode; hsize_i is not decoded, so transfers of any size reach the map
  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign addr_ofs = haddr_i[3:0];

  // next state of the top level
  always_comb begin
    nxt_cur = cur_ff;
    w1c = '0;
    // switch gates follow the gated requests, fault pin follows the overcurrent and thermal faults
    nxt_cur.out = drive_req;
    nxt_cur.fault_oe_n = ~any_fault;
    nxt_cur.therm_prev = thermal_shutdown_i;
    nxt_cur.undervoltage_lockout_prev = undervoltage_lockout_i;
    // write data phase
    nxt_cur.wr_pend = 1'b0;
    if (cur_ff.wr_pend) begin
      unique case (cur_ff.wr_addr)
        `QLFC_CTRL_OFS: begin
          nxt_cur.ctrl = hwdata_i[`QLFC_CTRL_ALLOW_LSB +: 4];
        end
        `QLFC_INT_STAT_OFS: begin
          w1c = hwdata_i[`QLFC_INT_W-1:0];
        end
        `QLFC_INT_MASK_OFS: begin
          nxt_cur.int_mask = hwdata_i[`QLFC_INT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    nxt_cur.int_stat = (cur_ff.int_stat & ~w1c) | events;
    // address phase: latch writes, fetch read data into the data flop
    nxt_cur.rdata = 32'h0000_0000;
    if (addr_phase) begin
      if (hwrite_i) begin
        nxt_cur.wr_pend = 1'b1;
        nxt_cur.wr_addr = addr_ofs;
      end else begin
        unique case (addr_ofs)
          `QLFC_CTRL_OFS: begin
            nxt_cur.rdata = {28'h000_0000, cur_ff.ctrl};
          end
          `QLFC_STATUS_OFS: begin
            nxt_cur.rdata = status_word;
          end
          `QLFC_INT_STAT_OFS: begin
            nxt_cur.rdata = {26'h000_0000, cur_ff.int_stat};
          end
          `QLFC_INT_MASK_OFS: begin
            nxt_cur.rdata = {26'h000_0000, cur_ff.int_mask};
          end
          default: begin
            nxt_cur.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
    // one level interrupt from unmasked sticky bits
    nxt_cur.irq = |(nxt_cur.int_stat & nxt_cur.int_mask);
  end

  // state register; power-up reset leaves every channel off
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cur_ff.out <= 4'h0;
      cur_ff.fault_oe_n <= 1'b1;
      cur_ff.irq <= 1'b0;
      cur_ff.ctrl <= `QLFC_CTRL_RST;
      cur_ff.int_stat <= '0;
      cur_ff.int_mask <= `QLFC_INT_MASK_RST;
      cur_ff.therm_prev <= 1'b0;
      cur_ff.undervoltage_lockout_prev <= 1'b0;
      cur_ff.wr_pend <= 1'b0;
      cur_ff.wr_addr <= 4'h0;
      cur_ff.rdata <= 32'h0000_0000;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs
  assign channel_output_o = cur_ff.out;
  assign fault_flag_low_o = 1'b0; // open drain only ever pulls low
  assign fault_flag_low_oe_n_o = cur_ff.fault_oe_n;
  assign hreadyout_o = 1'b1; // zero wait states
  assign hresp_o = 1'b0; // always OKAY
  assign hrdata_o = cur_ff.rdata;
  assign irq_o = cur_ff.irq;

endmodule // qlfc_top

// file: bench/qlfc_host.sv
// host side model: shorted-load current limit flags and the pulled-up fault wire
// assumes the switch gate and fault pin levels of qlfc_top as inputs
`timescale 1ns/1ns

module qlfc_host (
  input wire logic [3:0] channel_output_o,
  input wire logic [3:0] load_short_i,
  input wire logic fault_flag_low_o,
  input wire logic fault_flag_low_oe_n_o,
  output logic [3:0] current_limit_o,
  output logic fault_wire_o
);
  // limit only while the switch conducts into a shorted load
  assign current_limit_o = channel_output_o & load_short_i;
  // open-drain wire, pull-up wins when released
  assign fault_wire_o = fault_flag_low_oe_n_o ? 1'b1 : fault_flag_low_o;
endmodule // qlfc_host

// file: bench/qlfc_top_asserts.sv
// timing checks on the pins of the fault control block
// assumes one clock domain and the synchronous reset_i
`timescale 1ns/1ns
`include "qlfc_regs.svh"

module qlfc_top_asserts #(
  parameter int unsigned RETRY_CYCLES = `QLFC_OC_RETRY_NS / `QLFC_CLK_PERIOD_NS
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] channel_input_i,
  input wire logic outputs_enable_low_i,
  input wire logic logic_reset_i,
  input wire logic [3:0] current_limit_i,
  input wire logic thermal_shutdown_i,
  input wire logic undervoltage_lockout_i,
  input wire logic [3:0] channel_output_o,
  input wire logic fault_flag_low_oe_n_o
);
  logic [9:0] lim_ff;
  logic [17:0] off_ff;
  logic oth;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // causes of shutdown other than overcurrent, the enable pin and the allow bits
  assign oth = thermal_shutdown_i | logic_reset_i | undervoltage_lockout_i;
  // run length of limit while on, and of fault pulled low
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || (current_limit_i & channel_output_o) == 4'h0) lim_ff <= 10'h0;
    else if (lim_ff != 10'h3FF) lim_ff <= lim_ff + 10'h1;
    if (reset_i || fault_flag_low_oe_n_o) off_ff <= 18'h0;
    else off_ff <= off_ff + 18'h1;
  end
  en_off_a: assert property (outputs_enable_low_i |=> channel_output_o == 4'h0)
    else $error("output on while disabled");
  in_gate_a: assert property ((channel_output_o & ~$past(channel_input_i)) == 4'h0)
    else $error("output on without its input");
  rst_off_a: assert property (logic_reset_i |=> channel_output_o == 4'h0)
    else $error("output on during reset pin");
  rst_clr_a: assert property (logic_reset_i && $past(logic_reset_i) && $past(logic_reset_i, 2)
    && !thermal_shutdown_i && !$past(thermal_shutdown_i) |-> fault_flag_low_oe_n_o)
    else $error("fault held through reset pin");
  undervoltage_lockout_off_a: assert property (undervoltage_lockout_i |=> channel_output_o == 4'h0)
    else $error("output on in lockout");
  therm_off_a: assert property (thermal_shutdown_i |=> channel_output_o == 4'h0
    && !fault_flag_low_oe_n_o) else $error("thermal shutdown missed");
  trip_late_a: assert property ($fell(fault_flag_low_oe_n_o) && !$past(oth) |-> lim_ff >= 351)
    else $error("overcurrent trip too early");
  trip_bound_a: assert property (lim_ff <= 10'd355)
    else $error("overcurrent trip too late");
  retry_len_a: assert property ($rose(fault_flag_low_oe_n_o) && !$past(oth) && !$past(oth, 2)
    && !$past(oth, 3) |-> off_ff >= RETRY_CYCLES - 1 && off_ff <= RETRY_CYCLES + 3)
    else $error("retry time wrong");
endmodule // qlfc_top_asserts

bind qlfc_top qlfc_top_asserts #(.RETRY_CYCLES(RETRY_CYCLES)) chk_u (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .channel_input_i(channel_input_i),
  .outputs_enable_low_i(outputs_enable_low_i), .logic_reset_i(logic_reset_i),
  .current_limit_i(current_limit_i), .thermal_shutdown_i(thermal_shutdown_i),
  .undervoltage_lockout_i(undervoltage_lockout_i), .channel_output_o(channel_output_o),
  .fault_flag_low_oe_n_o(fault_flag_low_oe_n_o)
);

// file: bench/qlfc_top_tb.sv
// register and pin level bench of the fault control block
// assumes qlfc_host on the far side and a short retry count
`timescale 1ns/1ns

module qlfc_top_tb;
  import qlfc_pkg::*;
  localparam int RT = 50;
  logic ref_clk_i = 0, reset_i = 1, outputs_enable_low_i = 0, logic_reset_i = 0;
  logic thermal_shutdown_i = 0, undervoltage_lockout_i = 0, hsel_i = 0, hwrite_i = 0;
  logic [3:0] channel_input_i = 4'h0, load_short = 4'h0, current_limit_i, channel_output_o;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, q;
  logic hreadyout_o, hresp_o, irq_o, fault_o, fault_oe_n, fault_wire;
  int mismatches = 0, checks = 0, n;
  // clock
  always #5 ref_clk_i = ~ref_clk_i;
  qlfc_top #(.RETRY_CYCLES(RT)) dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .channel_input_i(channel_input_i), .outputs_enable_low_i(outputs_enable_low_i),
    .logic_reset_i(logic_reset_i), .current_limit_i(current_limit_i),
    .thermal_shutdown_i(thermal_shutdown_i), .undervoltage_lockout_i(undervoltage_lockout_i),
    .channel_output_o(channel_output_o), .fault_flag_low_i(fault_wire),
    .fault_flag_low_o(fault_o), .fault_flag_low_oe_n_o(fault_oe_n), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o), .irq_o(irq_o));
  qlfc_host host_u (.channel_output_o(channel_output_o), .load_short_i(load_short),
    .fault_flag_low_o(fault_o), .fault_flag_low_oe_n_o(fault_oe_n),
    .current_limit_o(current_limit_i), .fault_wire_o(fault_wire));
  task summarize;
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  // bounded wait for hready at a rising edge
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 100);
    if (hreadyout_o !== 1'b1) begin
      mismatches++;
      summarize;
    end
  endtask
  // one single word transfer, read data kept in q
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    rdy;
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy;
    q = hrdata_o;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task outs(input logic [3:0] e);
    wt(3);
    check({28'h0, channel_output_o}, {28'h0, e});
  endtask
  // bounded wait for the fault wire level, cycles in n
  task wwire(input logic lvl);
    n = 0;
    while (fault_wire !== lvl && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      summarize;
    end
  endtask
  // main sequence
  initial begin
    wt(16);
    reset_i <= 1'b0;
    rd(32'h0, 32'hF);
    rd(32'hC, 32'h0);
    rd(32'h10, 32'hF); // upper address bits ignored, aliases the control word
    xfer(1'b1, 32'hC, 32'h3F);
    rd(32'hC, 32'h3F);
    channel_input_i <= 4'hF;
    outs(4'hF);
    channel_input_i <= 4'h5;
    outs(4'h5);
    xfer(1'b1, 32'h0, 32'h1);
    outs(4'h1);
    xfer(1'b1, 32'h0, 32'hF);
    channel_input_i <= 4'hF;
    outputs_enable_low_i <= 1'b1;
    outs(4'h0);
    outputs_enable_low_i <= 1'b0;
    outs(4'hF);
    load_short <= 4'h1;
    wwire(1'b0);
    check(n >= 351 && n <= 356, 1);
    check({28'h0, channel_output_o}, 32'hE);
    check(irq_o, 1);
    rd(32'h8, 32'h1);
    load_short <= 4'h0;
    wwire(1'b1);
    check(n >= RT - 8 && n <= RT + 2, 1);
    outs(4'hF);
    xfer(1'b1, 32'h8, 32'h1);
    rd(32'h8, 32'h0);
    wt(2);
    check(irq_o, 0);
    xfer(1'b1, 32'hC, 32'h0);
    thermal_shutdown_i <= 1'b1;
    outs(4'h0);
    check(fault_wire, 0);
    check(irq_o, 0);
    rd(32'h8, 32'h10);
    rd(32'h4, 32'hF100);
    thermal_shutdown_i <= 1'b0;
    outs(4'hF);
    check(fault_wire, 1);
    xfer(1'b1, 32'hC, 32'h3F);
    wt(2);
    check(irq_o, 1);
    load_short <= 4'h2;
    wwire(1'b0);
    logic_reset_i <= 1'b1;
    load_short <= 4'h0;
    outputs_enable_low_i <= 1'b1;
    outs(4'h0);
    check(fault_wire, 1);
    logic_reset_i <= 1'b0;
    outputs_enable_low_i <= 1'b0;
    outs(4'hF);
    undervoltage_lockout_i <= 1'b1;
    outs(4'h0);
    rd(32'h8, 32'h32);
    undervoltage_lockout_i <= 1'b0;
    outs(4'hF);
    summarize;
  end
endmodule // qlfc_top_tb
